// *** bench/epa_core_model.sv ***
/*
  Core-side model: answers state push, vector fetch and state pop with
  one-cycle done pulses; the bench itself triggers handler completion.
  Assumes the arbiter's request pulses last exactly one cycle.
*/
`timescale 1ns/1ps
module epa_core_model #(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire epa_pkg::epa_core_req_s req_i,
  input wire logic hdone_i,
  output epa_pkg::epa_core_ack_s ack_o
);
  logic [7:0] push_q; // Delay line for the slow stacking
  logic [7:0] pop_q; // Delay line for the slow restore
  logic fetch_q; // Fetch finishes first, two cycles ahead of the push done
  // Stacking is slow and fetch is quick, so the two overlap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_q <= 8'h00;
      pop_q <= 8'h00;
      fetch_q <= 1'b0;
    end else begin
      push_q <= {push_q[6:0], req_i.push};
      pop_q <= {pop_q[6:0], req_i.pop};
      fetch_q <= req_i.fetch;
    end
  end
  assign ack_o.push_done = push_q[DLY-1];
  assign ack_o.fetch_done = fetch_q;
  assign ack_o.pop_done = pop_q[DLY-1];
  assign ack_o.handler_done = hdone_i;
endmodule

// *** bench/epa_top_tb.sv ***
/*
  Arbiter bench: Wishbone tasks, request scenarios, verdict.
  Assumes a 50 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("mismatch %0t got %h exp %h", $time, a, e); \
  end \
end
module epa_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs = 1'b0; // cyc and stb move together
  logic we = 1'b0;
  logic ack, hd = 1'b0, hm, iq;
  logic tk = 1'b0; // System tick pin
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q, irq = 32'h0;
  epa_pkg::epa_sys_in_s sys = '0;
  epa_pkg::epa_core_ack_s cack;
  epa_pkg::epa_core_req_s creq, r, seen = '0; // seen: last pulse observed
  int fail_count = 0;
  int n_tests = 0;
  always #10 clk_i = ~clk_i;
  epa_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cs), .stb_i(cs), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack), .irq_i(irq),
    .tick_i(tk), .sys_i(sys), .core_ack_i(cack), .core_req_o(creq),
    .handler_mode_o(hm), .irq_o(iq));
  epa_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(creq), .hdone_i(hd),
    .ack_o(cack));
  // Keep the last pulse, since one raised while a bus task runs is missed there
  always @(posedge clk_i) if ((creq.push | creq.chain | creq.pop) === 1'b1) seen <= creq;
  // Hold the request until ack is seen at an edge, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cs <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      $display("mismatch %0t bus timeout", $time);
      test_done();
    end
    q = rd;
    cs <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // Bounded wait for the next push, chain or pop pulse
  task automatic waitreq();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if ((creq.push | creq.chain | creq.pop) === 1'b1) break;
    end
    r = creq;
  endtask
  task automatic hdone();
    hd <= 1'b1;
    @(posedge clk_i);
    hd <= 1'b0;
  endtask
  task automatic test_done();
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(8'h1C, 32'h0);
    rchk(8'h3C, 32'h0);
    rchk(8'h44, 32'h0);
    bus(1'b1, 8'h1C, 32'h0765_4321);
    rchk(8'h1C, 32'h0765_4321);
    bus(1'b1, 8'h00, 32'hFFFF_FFFF);
    rchk(8'h00, epa_pkg::IRQ_IMPL_MASK);
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    bus(1'b1, 8'h00, 32'h4000_000F);
    bus(1'b1, 8'h18, 32'h7);
    bus(1'b1, 8'h20, 32'h0001_0101);
    // Reserved lines 30 and 31 alone must stay silent
    irq <= 32'hC000_0000;
    waitreq();
    `CHK(r.push, 1'b0)
    irq <= 32'hC000_0007;
    waitreq();
    `CHK({r.push, r.fetch, r.pos}, {2'b11, 6'h10})
    `CHK(hm, 1'b1)
    repeat (10) @(posedge clk_i);
    irq <= 32'hC000_000F;
    waitreq();
    `CHK({r.push, r.pos}, {1'b1, 6'h13})
    bus(1'b1, 8'h04, 32'h8);
    repeat (5) @(posedge clk_i);
    hdone();
    waitreq();
    `CHK({r.chain, r.push, r.pos}, {2'b10, 6'h10})
    irq <= 32'h0;
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    repeat (5) @(posedge clk_i);
    hdone();
    waitreq();
    `CHK(r.pop, 1'b1)
    repeat (6) @(posedge clk_i);
    `CHK(hm, 1'b0)
    // One-cycle tick pulse enters at its own position, then returns
    tk <= 1'b1;
    @(posedge clk_i);
    tk <= 1'b0;
    waitreq();
    `CHK({r.push, r.pos}, {1'b1, epa_pkg::POS_TICK})
    repeat (6) @(posedge clk_i);
    hdone();
    waitreq();
    `CHK(r.pop, 1'b1)
    repeat (6) @(posedge clk_i);
    // Sticky events, mask and write-one-to-clear
    rchk(8'h14, 32'h7);
    `CHK(iq, 1'b1)
    bus(1'b1, 8'h18, 32'h0);
    `CHK(iq, 1'b0)
    bus(1'b1, 8'h18, 32'h7);
    bus(1'b1, 8'h14, 32'h7);
    rchk(8'h14, 32'h0);
    `CHK(iq, 1'b0)
    // Fault and a level 0 line are raised in one cycle: fault wins
    irq <= 32'h8;
    sys.fault <= 1'b1;
    bus(1'b1, 8'h00, 32'h8);
    @(posedge clk_i);
    sys.fault <= 1'b0;
    `CHK(seen.pos, epa_pkg::POS_HARD)
    // Group 3, software NMI and service request pend in one write
    bus(1'b1, 8'h0C, 32'h33);
    repeat (6) @(posedge clk_i);
    `CHK({seen.push, seen.pos}, {1'b1, epa_pkg::POS_NMI})
    rchk(8'h0C, 32'h23);
    test_done();
  end
  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    $display("mismatch %0t watchdog", $time);
    test_done();
  end
endmodule

// *** logic/epa_pick.sv ***
/*
  Combinational selector of the most urgent pending request among a set
  of sources, each with a level and an index.
  Assumes levels where lower means more urgent and that source index
  order follows ascending exception position.
*/
`timescale 1ns/1ps
module epa_pick #(
  parameter int N = 39,
  parameter int LW = 4
) (
  input wire logic [N-1:0] valid_i,
  input wire logic [N*LW-1:0] level_i,
  output logic found_o,
  output logic [5:0] index_o,
  output logic [LW-1:0] level_o
);

  // ----------------------------------------------------------------
  // Linear scan; strict compare keeps the lowest index on a tie
  // ----------------------------------------------------------------
  always_comb begin
    found_o = 1'b0;
    index_o = 6'h00;
    level_o = '1;
    for (int i = 0; i < N; i++) begin
      // Earlier index wins equal levels
      if (valid_i[i] && (!found_o || level_i[i*LW +: LW] < level_o)) begin
        found_o = 1'b1;
        index_o = 6'(i);
        level_o = level_i[i*LW +: LW];
      end
    end
  end

endmodule

// *** logic/epa_pkg.sv ***
/*
  Shared constants and carrier types of the exception priority arbiter:
  register offsets, field layouts, reset values, exception positions and
  the structs that group the core-facing signals.
  Assumes a 32-bit classic Wishbone register bus and one 50 MHz clock.
*/
package epa_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 32;          // Interrupt bit positions
  localparam int NUM_SYS = 7;           // Settable system handlers
  localparam int PRIO_W = 3;            // Eight levels
  localparam int POS_W = 6;             // Exception position width
  localparam int NUM_SRC = NUM_SYS + NUM_IRQ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_EN = 8'h00;   // Set-enable, write 1 sets
  localparam logic [7:0] OFS_IRQ_CLR = 8'h04;  // Clear-enable, write 1 clears
  localparam logic [7:0] OFS_IRQ_PEND = 8'h08; // Pending view (read)
  localparam logic [7:0] OFS_CTRL = 8'h0C;     // Grouping, pend bits
  localparam logic [7:0] OFS_STATE = 8'h10;    // State / candidate view
  localparam logic [7:0] OFS_ISTAT = 8'h14;    // Sticky event status, W1C
  localparam logic [7:0] OFS_IMASK = 8'h18;    // Event mask
  localparam logic [7:0] OFS_SYS_PRIO = 8'h1C; // 7 x 4-bit slots
  localparam logic [7:0] OFS_IRQ_PRIO = 8'h20; // 8 words x 4 slots of 8 bits

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GROUP_LSB = 0;      // Grouping, 3 bits
  localparam int CTRL_NMI_PEND = 4;       // Software NMI pend
  localparam int CTRL_PSR_PEND = 5;       // Pendable service request pend
  localparam logic [31:0] IRQ_IMPL_MASK = 32'h3FFC_01FF;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic [2:0] GROUP_RST = 3'h0;

  // ----------------------------------------------------------------
  // Exception positions
  // ----------------------------------------------------------------
  localparam logic [POS_W-1:0] POS_NONE = 6'h00;
  localparam logic [POS_W-1:0] POS_RESET = 6'h01;
  localparam logic [POS_W-1:0] POS_NMI = 6'h02;
  localparam logic [POS_W-1:0] POS_HARD = 6'h03;
  localparam logic [POS_W-1:0] POS_PSR = 6'h0E;
  localparam logic [POS_W-1:0] POS_TICK = 6'h0F;
  localparam logic [POS_W-1:0] POS_IRQ0 = 6'h10;

  // Sticky event bits
  localparam int EV_ENTRY = 0;
  localparam int EV_CHAIN = 1;
  localparam int EV_RETURN = 2;
  localparam int EV_W = 3;

  // Entry and return sequencing states
  typedef enum logic [3:0] {
    ST_THREAD = 4'h1,
    ST_ENTER = 4'h2,
    ST_SERVICE = 4'h4,
    ST_EXIT = 4'h8
  } epa_state_e;

  // Request from the arbiter to the core
  typedef struct packed {
    logic push;                 // Start automatic state save
    logic fetch;                // Start vector fetch
    logic chain;                // Tail-chain into next handler
    logic pop;                  // Start automatic state restore
    logic [POS_W-1:0] pos;      // Exception position being entered, or left on a pop
  } epa_core_req_s;

  // Completion signals from the core
  typedef struct packed {
    logic push_done;
    logic fetch_done;
    logic pop_done;
    logic handler_done;         // Service routine returned
  } epa_core_ack_s;

  // Sources other than the interrupt lines
  typedef struct packed {
    logic [NUM_SYS-1:0] sys_req; // Settable system handler requests
    logic fault;                 // Fault that failed to activate
  } epa_sys_in_s;

endpackage

// *** logic/epa_top.sv ***
/*
  Exception priority arbiter: holds enables, priorities and grouping,
  picks the most urgent pending request and sequences entry, tail-chain
  and return with the processor core.
  Assumes a classic Wishbone master, one clock, and a core that reports
  each stacking, fetch and handler completion with a one-cycle pulse.
*/
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module epa_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Request sources
  input wire logic [31:0] irq_i,
  input wire logic tick_i,
  input wire epa_pkg::epa_sys_in_s sys_i,
  // Core handshake
  input wire epa_pkg::epa_core_ack_s core_ack_i,
  output epa_pkg::epa_core_req_s core_req_o,
  output logic handler_mode_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int N = epa_pkg::NUM_SRC;
  localparam int LW = epa_pkg::PRIO_W + 1;    // Extra top bit for group split
  logic [31:0] irq_s1_q, irq_s2_q;            // Pin synchroniser
  logic tick_s1_q, tick_s2_q;
  logic [31:0] en_q;                          // Interrupt enables
  logic [31:0] pend_q;                        // Latched interrupt pendings
  logic [2:0] group_q;                        // Grouping point
  logic nmi_pend_q, psr_pend_q, tick_pend_q, fault_pend_q;
  logic [epa_pkg::PRIO_W-1:0] iprio_q [32];   // Per-interrupt levels
  logic [epa_pkg::PRIO_W-1:0] sprio_q [epa_pkg::NUM_SYS];
  logic [epa_pkg::EV_W-1:0] istat_q, imask_q;
  epa_pkg::epa_state_e state_q, state_d;
  logic [epa_pkg::POS_W-1:0] act_pos_q;       // Active exception
  logic [LW-1:0] act_grp_q;                   // Its pre-emption group
  logic act_fixed_q;                          // Active is NMI or hard fault
  logic push_ok_q, fetch_ok_q;
  logic ack_q;
  logic [31:0] dat_q;

  // ----------------------------------------------------------------
  // Pin synchronisers: two flops before any logic looks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    irq_s1_q <= irq_i;
    irq_s2_q <= irq_s1_q;
    tick_s1_q <= tick_i;
    tick_s2_q <= tick_s1_q;
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_req = cyc_i && stb_i && !ack_q;
  wire wr = bus_req && we_i;
  wire wr_en = wr && adr_i == epa_pkg::OFS_IRQ_EN;
  wire wr_clr = wr && adr_i == epa_pkg::OFS_IRQ_CLR;
  wire wr_ctrl = wr && adr_i == epa_pkg::OFS_CTRL;
  wire wr_istat = wr && adr_i == epa_pkg::OFS_ISTAT;
  wire wr_imask = wr && adr_i == epa_pkg::OFS_IMASK;
  wire wr_sprio = wr && adr_i == epa_pkg::OFS_SYS_PRIO;
  wire wr_iprio = wr && adr_i[7:5] == epa_pkg::OFS_IRQ_PRIO[7:5] && adr_i[1:0] == 2'h0;
  wire [2:0] iprio_word = adr_i[4:2];
  // Only implemented bits are storable or requestable
  wire [31:0] impl = epa_pkg::IRQ_IMPL_MASK;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // ----------------------------------------------------------------
  // Enable register: set-enable and clear-enable views
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 32'h0000_0000;
    end else if (wr_en) begin
      en_q <= en_q | (dat_i & wmask & impl);
    end else if (wr_clr) begin
      en_q <= en_q & ~(dat_i & wmask);
    end
  end

  // ----------------------------------------------------------------
  // Priority registers, all reset to level 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) iprio_q[i] <= epa_pkg::PRIO_RST;
      for (int i = 0; i < epa_pkg::NUM_SYS; i++) sprio_q[i] <= epa_pkg::PRIO_RST;
    end else begin
      // One byte per interrupt, level in the low bits
      for (int b = 0; b < 4; b++) begin
        if (wr_iprio && sel_i[b]) begin
          iprio_q[{iprio_word, 2'(b)}] <= dat_i[b*8 +: epa_pkg::PRIO_W];
        end
      end
      for (int s = 0; s < epa_pkg::NUM_SYS; s++) begin
        if (wr_sprio && sel_i[s/2]) begin
          sprio_q[s] <= dat_i[s*4 +: epa_pkg::PRIO_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control: grouping point and software pends
  // ----------------------------------------------------------------
  logic [5:0] win_idx;
  logic win_found;
  logic [LW-1:0] win_lvl;
  logic [epa_pkg::POS_W-1:0] win_pos;
  logic take;                                 // Candidate accepted this cycle
  wire take_nmi = take && win_pos == epa_pkg::POS_NMI;
  wire take_hard = take && win_pos == epa_pkg::POS_HARD;
  wire take_psr = take && win_pos == epa_pkg::POS_PSR;
  wire take_tick = take && win_pos == epa_pkg::POS_TICK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group_q <= epa_pkg::GROUP_RST;
      nmi_pend_q <= 1'b0;
      psr_pend_q <= 1'b0;
      tick_pend_q <= 1'b0;
      fault_pend_q <= 1'b0;
    end else begin
      if (wr_ctrl && sel_i[0]) group_q <= dat_i[epa_pkg::CTRL_GROUP_LSB +: 3];
      // Set beats the acceptance that clears it
      nmi_pend_q <= (nmi_pend_q && !take_nmi) || (wr_ctrl && sel_i[0] &&
                    dat_i[epa_pkg::CTRL_NMI_PEND]);
      psr_pend_q <= (psr_pend_q && !take_psr) || (wr_ctrl && sel_i[0] &&
                    dat_i[epa_pkg::CTRL_PSR_PEND]);
      tick_pend_q <= (tick_pend_q && !take_tick) || tick_s2_q;
      fault_pend_q <= (fault_pend_q && !take_hard) || sys_i.fault;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pending latch; reserved bits never set
  // ----------------------------------------------------------------
  logic [31:0] take_irq;
  always_comb begin
    take_irq = 32'h0000_0000;
    if (take && win_pos >= epa_pkg::POS_IRQ0) begin
      take_irq[5'(win_pos - epa_pkg::POS_IRQ0)] = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) pend_q <= 32'h0000_0000;
    else pend_q <= ((pend_q & ~take_irq) | irq_s2_q) & impl;
  end

  // ----------------------------------------------------------------
  // Candidate table: index order equals position order
  // Sys slots map to positions 4,5,6,11,12,14,15
  // ----------------------------------------------------------------
  logic [N-1:0] cand_v;
  logic [N*LW-1:0] cand_l;
  logic [epa_pkg::POS_W-1:0] pos_of [N];
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      if (g < epa_pkg::NUM_SYS) begin : g_sys
        // Tick and service request slots take their internal pend
        localparam logic [5:0] SP = (g < 3) ? 6'(g + 4) : (g < 5) ? 6'(g + 8) : 6'(g + 9);
        assign pos_of[g] = SP;
        assign cand_v[g] = (g == 5) ? psr_pend_q : (g == 6) ? tick_pend_q : sys_i.sys_req[g];
        assign cand_l[g*LW +: LW] = {1'b0, sprio_q[g]};
      end else begin : g_irq
        localparam int B = g - epa_pkg::NUM_SYS;
        assign pos_of[g] = 6'(B + 16);
        // Pending and enabled only
        assign cand_v[g] = pend_q[B] && en_q[B];
        assign cand_l[g*LW +: LW] = {1'b0, iprio_q[B]};
      end
    end
  endgenerate

  epa_pick #(.N(N), .LW(LW)) u_pick (
    .valid_i(cand_v),
    .level_i(cand_l),
    .found_o(win_found),
    .index_o(win_idx),
    .level_o(win_lvl)
  );

  // ----------------------------------------------------------------
  // Fixed exceptions outrank every settable level
  // ----------------------------------------------------------------
  wire fixed_nmi = nmi_pend_q;
  wire fixed_hard = fault_pend_q && !fixed_nmi;
  assign win_pos = fixed_nmi ? epa_pkg::POS_NMI :
                   fixed_hard ? epa_pkg::POS_HARD : pos_of[win_idx];
  wire any_cand = fixed_nmi || fixed_hard || win_found;

  // Pre-emption part: bits at and above the grouping point
  wire [LW-1:0] grp_mask = LW'(4'hF << group_q);
  wire [LW-1:0] win_grp = win_lvl & grp_mask;

  // NMI beats all but reset, fault beats settable; strict compare
  wire preempt = fixed_nmi ? (act_pos_q != epa_pkg::POS_NMI) :
                 fixed_hard ? !act_fixed_q :
                 (win_found && !act_fixed_q && win_grp < act_grp_q);

  // ----------------------------------------------------------------
  // Entry / return sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    take = 1'b0;
    case (state_q)
      epa_pkg::ST_THREAD: begin
        // Any candidate enters from thread
        if (any_cand) begin
          take = 1'b1;
          state_d = epa_pkg::ST_ENTER;
        end
      end
      epa_pkg::ST_ENTER: begin
        if (push_ok_q && fetch_ok_q) state_d = epa_pkg::ST_SERVICE;
      end
      epa_pkg::ST_SERVICE: begin
        if (core_ack_i.handler_done && any_cand) begin
          // Tail-chain: no pop, no second push
          take = 1'b1;
          state_d = epa_pkg::ST_ENTER;
        end else if (core_ack_i.handler_done) begin
          state_d = epa_pkg::ST_EXIT;
        end else if (any_cand && preempt) begin
          take = 1'b1;
          state_d = epa_pkg::ST_ENTER;
        end
      end
      epa_pkg::ST_EXIT: begin
        if (core_ack_i.pop_done) state_d = epa_pkg::ST_THREAD;
      end
      default: state_d = epa_pkg::ST_THREAD;
    endcase
  end

  wire chaining = state_q == epa_pkg::ST_SERVICE && core_ack_i.handler_done && take;
  epa_pkg::epa_core_req_s req_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= epa_pkg::ST_THREAD;
      act_pos_q <= epa_pkg::POS_NONE;
      act_grp_q <= {1'b1, {epa_pkg::PRIO_W{1'b0}}};
      act_fixed_q <= 1'b0;
      push_ok_q <= 1'b0;
      fetch_ok_q <= 1'b0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= '0;
      if (take) begin
        act_pos_q <= win_pos;
        act_grp_q <= (fixed_nmi || fixed_hard) ? '0 : win_grp;
        act_fixed_q <= fixed_nmi || fixed_hard;
        // Push and fetch start together; on a tail-chain, chain and fetch
        req_q.push <= !chaining;
        req_q.fetch <= 1'b1;
        req_q.chain <= chaining;
        req_q.pos <= win_pos;
        push_ok_q <= chaining;
        fetch_ok_q <= 1'b0;
      end else begin
        if (core_ack_i.push_done) push_ok_q <= 1'b1;
        if (core_ack_i.fetch_done) fetch_ok_q <= 1'b1;
      end
      if (state_q == epa_pkg::ST_SERVICE && state_d == epa_pkg::ST_EXIT) begin
        // Restore on plain return
        req_q.pop <= 1'b1;
        req_q.pos <= act_pos_q;
      end
      if (state_d == epa_pkg::ST_THREAD && state_q == epa_pkg::ST_EXIT) begin
        act_pos_q <= epa_pkg::POS_NONE;
        act_grp_q <= {1'b1, {epa_pkg::PRIO_W{1'b0}}};
        act_fixed_q <= 1'b0;
      end
    end
  end
  assign core_req_o = req_q;
  assign handler_mode_o = state_q != epa_pkg::ST_THREAD;

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line; set wins over clear
  // ----------------------------------------------------------------
  wire [epa_pkg::EV_W-1:0] ev = {req_q.pop, req_q.chain, req_q.push};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_q <= '0;
      imask_q <= '0;
    end else begin
      istat_q <= (istat_q & ~(wr_istat && sel_i[0] ? dat_i[epa_pkg::EV_W-1:0] : '0)) | ev;
      if (wr_imask && sel_i[0]) imask_q <= dat_i[epa_pkg::EV_W-1:0];
    end
  end
  assign irq_o = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // Read mux and single-wait acknowledge
  // ----------------------------------------------------------------
  logic [31:0] iprio_rd, sprio_rd;
  always_comb begin
    iprio_rd = 32'h0000_0000;
    sprio_rd = 32'h0000_0000;
    for (int b = 0; b < 4; b++) iprio_rd[b*8 +: 3] = iprio_q[{iprio_word, 2'(b)}];
    for (int s = 0; s < epa_pkg::NUM_SYS; s++) sprio_rd[s*4 +: 3] = sprio_q[s];
  end
  wire [31:0] rd =
    (adr_i == epa_pkg::OFS_IRQ_EN || adr_i == epa_pkg::OFS_IRQ_CLR) ? en_q :
    adr_i == epa_pkg::OFS_IRQ_PEND ? pend_q :
    adr_i == epa_pkg::OFS_CTRL ? {26'h0, psr_pend_q, nmi_pend_q, 1'b0, group_q} :
    adr_i == epa_pkg::OFS_STATE ? {16'h0, 2'h0, win_pos, 4'h0, state_q} :
    adr_i == epa_pkg::OFS_ISTAT ? {29'h0, istat_q} :
    adr_i == epa_pkg::OFS_IMASK ? {29'h0, imask_q} :
    adr_i == epa_pkg::OFS_SYS_PRIO ? sprio_rd :
    wr_iprio || (adr_i[7:5] == 3'h1 && adr_i[1:0] == 2'h0) ? iprio_rd : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !we_i) dat_q <= rd;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_take_plain;
    state_q == epa_pkg::ST_THREAD && take;
  endsequence

  a_entry_starts: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take_plain |=> core_req_o.push && core_req_o.fetch)
    else $error("entry did not start push and fetch together");
  a_chain_nopop: assert property (@(posedge clk_i) disable iff (rst_i)
    chaining |=> core_req_o.chain && !core_req_o.push && !core_req_o.pop)
    else $error("tail chain restored or re-saved state");
  a_return_pops: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == epa_pkg::ST_SERVICE && core_ack_i.handler_done && !any_cand)
    |=> core_req_o.pop && state_q == epa_pkg::ST_EXIT)
    else $error("return without state restore");
  a_handler_state: assert property (@(posedge clk_i) disable iff (rst_i)
    core_req_o.fetch |-> handler_mode_o)
    else $error("exception entered outside handler state");
  a_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (pend_q & ~epa_pkg::IRQ_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved interrupt bit pending");
  a_nmi_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (nmi_pend_q && take) |-> win_pos == epa_pkg::POS_NMI)
    else $error("settable level beat pending NMI");
  a_strict_preempt: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == epa_pkg::ST_SERVICE && !core_ack_i.handler_done && take && !act_fixed_q
     && !fixed_nmi && !fixed_hard) |-> win_grp < act_grp_q)
    else $error("pre-emption without more urgent group");
  a_prio_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> iprio_q[0] == 3'h0 && sprio_q[0] == 3'h0)
    else $error("priority not zero after reset");

endmodule
